// >>> dv/depec_monitor.sv
// checker of bus timing and register read-back of the eeprom controller
// assumes it is bound to depec_top and sees only its ports
`timescale 1ns/10ps

module depec_monitor (
	input wire logic clk, // system clock
	input wire logic rst, // synchronous reset
	input wire logic wb_cyc_i, // cycle
	input wire logic wb_stb_i, // strobe
	input wire logic wb_we_i, // write enable
	input wire logic [7:0] wb_adr_i, // byte address
	input wire logic [3:0] wb_sel_i, // byte enables
	input wire logic [31:0] wb_dat_i, // write data
	input wire logic [31:0] wb_dat_o, // read data
	input wire logic wb_ack_o, // acknowledge
	input wire logic external_pin_reset, // pin reset request
	input wire logic watchdog_reset_source // watchdog reset request
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_take;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_rd(logic [7:0] a);
		wb_ack_o && !wb_we_i && wb_adr_i == a;
	endsequence

	property p_ack_next;
		s_take |=> wb_ack_o;
	endproperty
	a_ack_next: assert property (p_ack_next) else $error("ack missing after request");
	property p_ack_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
	property p_no_stray;
		!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o;
	endproperty
	a_no_stray: assert property (p_no_stray) else $error("ack without request");
	property p_key_wo;
		s_rd(depec_pkg::ADDR_KEY) |-> wb_dat_o == 32'h00000000;
	endproperty
	a_key_wo: assert property (p_key_wo) else $error("key register readable");
	property p_ctl_zero;
		s_rd(depec_pkg::ADDR_CONTROL) |-> wb_dat_o[31:16] == 16'h0000 && wb_dat_o[11:7] == 5'h00;
	endproperty
	a_ctl_zero: assert property (p_ctl_zero) else $error("unused control bits nonzero");
	property p_start_permit;
		s_rd(depec_pkg::ADDR_CONTROL) ##0 wb_dat_o[15] |-> wb_dat_o[14];
	endproperty
	a_start_permit: assert property (p_start_permit) else $error("running without permit");
	property p_addr_even;
		s_rd(depec_pkg::ADDR_CAPTURED) |-> wb_dat_o[0] == 1'b0 && wb_dat_o[31:23] == 9'h000;
	endproperty
	a_addr_even: assert property (p_addr_even) else $error("captured address malformed");
	property p_dat_hold;
		!(wb_ack_o && !wb_we_i) |-> $stable(wb_dat_o);
	endproperty
	a_dat_hold: assert property (p_dat_hold) else $error("read data moved without read");
endmodule // depec_monitor

bind depec_top depec_monitor u_mon (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .external_pin_reset(external_pin_reset), .watchdog_reset_source(watchdog_reset_source));

// >>> dv/depec_sw_model.sv
// software-side bus model: one classic wishbone cycle at a time
// assumes a slave on clk that answers each request with a one-cycle ack
`timescale 1ns/10ps

module depec_sw_model (
	input wire logic clk, // system clock
	output logic cyc, // cycle
	output logic stb, // strobe
	output logic we, // write enable
	output logic [7:0] adr, // byte address
	output logic [3:0] sel, // byte enables
	output logic [31:0] dat, // write data
	input wire logic [31:0] dat_i, // read data
	input wire logic ack // acknowledge
);
	initial
	begin
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		sel = 4'h0;
		dat = 32'h00000000;
	end

	// nothing is ever interleaved, so a key pair and its control write stay together
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hF;
		dat <= d;
		// ack and read data are taken at the rising edge, as the slave's own flops see them
		do
			@(posedge clk);
		while (ack !== 1'b1);
		q = dat_i;
		cyc <= 1'b0;
		stb <= 1'b0;
		// released address and data lines show junk, not the last value
		adr <= ~a;
		dat <= ~d;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		xfer(1'b0, a, 32'h00000000, q);
	endtask
endmodule // depec_sw_model

// >>> dv/tb_data_eeprom_program_erase_ctrl.sv
// testbench: drives the controller through the software model and checks registers and array
// assumes the bus model answers calls in order and the array word sits at pointer bits 8..1
`timescale 1ns/10ps

module tb_data_eeprom_program_erase_ctrl;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic pin_rst = 1'b0;
	logic wdt_rst = 1'b0;
	logic cyc, stb, we, ack;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] dat_w, dat_r, v;
	logic [15:0] e [16];
	logic [7:0] ra [6] = '{depec_pkg::ADDR_CONTROL, depec_pkg::ADDR_STATUS, depec_pkg::ADDR_CAPTURED,
		depec_pkg::ADDR_TABLE_POINTER, depec_pkg::ADDR_KEY, 8'h20};
	logic [15:0] bad [3] = '{16'h8058, 16'hC07F, 16'hC018};
	int ix [3] = '{3, 5, 9};
	int nw [3] = '{1, 4, 8};
	int err_count = 0;
	int n_checks = 0;

	always #20 clk = ~clk;

	depec_sw_model u_sw (.clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel), .dat(dat_w),
		.dat_i(dat_r), .ack(ack));
	depec_top u_dut (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack), .external_pin_reset(pin_rst),
		.watchdog_reset_source(wdt_rst));

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic summarize;
		$display("checks=%0d errors=%0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	function automatic logic [23:0] wa(input int i);
		return depec_pkg::EE_BASE + 24'(2 * i);
	endfunction

	task automatic unlock;
		u_sw.wr(depec_pkg::ADDR_KEY, {24'h000000, depec_pkg::KEY_FIRST});
		u_sw.wr(depec_pkg::ADDR_KEY, {24'h000000, depec_pkg::KEY_SECOND});
	endtask

	// ab: 0 runs to the end, 1 pin reset, 2 watchdog reset in mid-operation
	task automatic op(input logic [23:0] p, input logic [15:0] d, input logic [15:0] c, input bit go, input int ab);
		u_sw.wr(depec_pkg::ADDR_STATUS, 32'h00000001);
		u_sw.wr(depec_pkg::ADDR_TABLE_POINTER, {8'h00, p});
		u_sw.wr(depec_pkg::ADDR_TABLE_DATA, {16'h0000, d});
		u_sw.rd(depec_pkg::ADDR_CAPTURED, v);
		chk(v, {8'h00, p});
		unlock();
		u_sw.wr(depec_pkg::ADDR_CONTROL, {16'h0000, c});
		u_sw.rd(depec_pkg::ADDR_STATUS, v);
		chk(v & 32'h00000002, go ? 32'h00000002 : 32'h00000000);
		if (ab != 0)
		begin
			repeat (10) @(posedge clk);
			pin_rst <= (ab == 1);
			wdt_rst <= (ab == 2);
			repeat (4) @(posedge clk);
			pin_rst <= 1'b0;
			wdt_rst <= 1'b0;
		end
		do
			u_sw.rd(depec_pkg::ADDR_CONTROL, v);
		while (v[15] === 1'b1);
		if (go)
			chk(v, {16'h0000, (c & 16'h107F) | (ab != 0 ? 16'h2000 : 16'h0000)});
		else
			chk(v & 32'h00008000, 32'h00000000);
		u_sw.rd(depec_pkg::ADDR_STATUS, v);
		chk(v, (go && ab == 0) ? 32'h00000001 : 32'h00000000);
	endtask

	task automatic verify;
		for (int i = 0; i < 16; i++)
		begin
			u_sw.wr(depec_pkg::ADDR_TABLE_POINTER, {8'h00, wa(i)});
			u_sw.rd(depec_pkg::ADDR_TABLE_DATA, v);
			chk(v, {16'h0000, e[i]});
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		u_sw.wr(8'h20, 32'hFFFFFFFF);
		foreach (ra[k])
		begin
			u_sw.rd(ra[k], v);
			chk(v, 32'h00000000);
		end
		u_sw.wr(depec_pkg::ADDR_CONTROL, 32'h00000058);
		u_sw.wr(depec_pkg::ADDR_KEY, {24'h000000, depec_pkg::KEY_SECOND});
		u_sw.wr(depec_pkg::ADDR_KEY, {24'h000000, depec_pkg::KEY_FIRST});
		u_sw.wr(depec_pkg::ADDR_CONTROL, 32'h00000058);
		unlock();
		u_sw.rd(depec_pkg::ADDR_KEY, v);
		u_sw.wr(depec_pkg::ADDR_CONTROL, 32'h00000058);
		u_sw.rd(depec_pkg::ADDR_CONTROL, v);
		chk(v, 32'h00000000);
		unlock();
		u_sw.wr(depec_pkg::ADDR_CONTROL, 32'h00000FD8);
		u_sw.wr(depec_pkg::ADDR_CONTROL, 32'h00000019);
		u_sw.rd(depec_pkg::ADDR_CONTROL, v);
		chk(v, 32'h00000058);
		// bulk erase with a pointer outside the array
		op(24'h000000, 16'h0000, 16'hC053, 1'b1, 0);
		for (int i = 0; i < 16; i++)
			e[i] = 16'hFFFF;
		verify();
		for (int i = 0; i < 16; i++)
		begin
			e[i] = {12'hA50, 4'(i)};
			op(wa(i), e[i], {14'h3001, 2'(i)}, 1'b1, 0);
		end
		verify();
		op(wa(0), 16'h0F0F, 16'hD004, 1'b1, 0);
		e[0] = e[0] & 16'h0F0F;
		op(wa(1), 16'h5A5A, 16'hC004, 1'b1, 0);
		e[1] = 16'h5A5A;
		op(wa(2), 16'h0000, 16'hC058, 1'b1, 1);
		op(wa(2), 16'h0000, 16'hC058, 1'b1, 2);
		foreach (bad[k])
			op(wa(3), 16'h0000, bad[k], 1'b0, 0);
		for (int k = 0; k < 3; k++)
		begin
			op(wa(ix[k]), 16'h0000, 16'hC058 + 16'(k), 1'b1, 0);
			for (int j = 0; j < 16; j++)
				if (j / nw[k] == ix[k] / nw[k])
					e[j] = 16'hFFFF;
		end
		verify();
		summarize();
	end

	initial
	begin
		repeat (20000) @(posedge clk);
		err_count++;
		summarize();
	end
endmodule // tb_data_eeprom_program_erase_ctrl

// >>> hdl/depec_top.sv
// data eeprom program/erase controller: key unlock, control register, self-timed operations, array
// assumes a wishbone classic master on clk and asynchronous reset-source pins from the reset block
//
// Added by the designer: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/10ps

module depec_top (
	input wire logic clk, // system clock, 25 MHz
	input wire logic rst, // synchronous reset, active high
	input wire logic wb_cyc_i, // wishbone cycle
	input wire logic wb_stb_i, // wishbone strobe
	input wire logic wb_we_i, // wishbone write enable
	input wire logic [7:0] wb_adr_i, // wishbone byte address
	input wire logic [3:0] wb_sel_i, // wishbone byte enables
	input wire logic [31:0] wb_dat_i, // wishbone write data
	output logic [31:0] wb_dat_o, // wishbone read data
	output logic wb_ack_o, // wishbone acknowledge
	input wire logic external_pin_reset, // asynchronous pin reset request, high active
	input wire logic watchdog_reset_source // asynchronous watchdog reset request, high active
);

	////////////////////////////////////////////////////////////////////////////////
	// helpers
	function automatic logic [31:0] apply_sel(input logic [31:0] old_val, input logic [31:0] new_val,
		input logic [3:0] sel);
		logic [31:0] res;
		res = old_val;
		for (int b = 0; b < 4; b++)
		begin
			if (sel[b])
			begin
				res[b*8 +: 8] = new_val[b*8 +: 8];
			end
		end
		return res;
	endfunction

	function automatic logic in_range(input logic [23:0] ea);
		return ea[23:9] == depec_pkg::EE_BASE[23:9];
	endfunction

	function automatic depec_pkg::depec_op_t op_decode(input logic erase_sel, input logic [5:0] code);
		depec_pkg::depec_op_t k;
		k = depec_pkg::OPK_NONE;
		if (erase_sel)
		begin
			if (code == depec_pkg::OP_ERASE8)
				k = depec_pkg::OPK_ERASE8;
			else if (code == depec_pkg::OP_ERASE4)
				k = depec_pkg::OPK_ERASE4;
			else if (code == depec_pkg::OP_ERASE1)
				k = depec_pkg::OPK_ERASE1;
			else if (code[5:2] == depec_pkg::OP_BULK_PREFIX)
				k = depec_pkg::OPK_BULK;
		end
		else if (code[5:2] == depec_pkg::OP_WRITE_PREFIX)
		begin
			k = depec_pkg::OPK_WRITE1;
		end
		return k;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// declarations
	logic pin_meta;
	logic pin_sync;
	logic wdt_meta;
	logic wdt_sync;
	logic abort_req;
	logic req;
	logic wr;
	depec_pkg::depec_key_t key_state;
	depec_pkg::depec_state_t state;
	logic [15:0] ctrl;
	logic [15:0] new_ctrl_raw;
	logic [15:0] new_ctrl;
	logic ctrl_accept;
	depec_pkg::depec_op_t new_kind;
	logic launch;
	logic busy;
	logic done_ev;
	logic abort_ev;
	logic [15:0] count;
	depec_pkg::depec_op_t op_kind;
	logic [7:0] op_index;
	logic [7:0] op_align;
	logic [15:0] op_data;
	logic op_skip;
	logic [23:0] table_pointer;
	logic [23:0] captured_addr;
	logic [15:0] write_latch;
	logic done_flag;
	logic [15:0] mem [depec_pkg::EE_WORDS];
	logic [31:0] next_rdata;

	////////////////////////////////////////////////////////////////////////////////
	// reset-source pins cross into clk
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			pin_meta <= 1'b0;
			pin_sync <= 1'b0;
			wdt_meta <= 1'b0;
			wdt_sync <= 1'b0;
		end
		else
		begin
			pin_meta <= external_pin_reset;
			pin_sync <= pin_meta;
			wdt_meta <= watchdog_reset_source;
			wdt_sync <= wdt_meta;
		end
	end

	assign abort_req = pin_sync | wdt_sync;

	////////////////////////////////////////////////////////////////////////////////
	// bus slave: every access answers one cycle later, busy or not
	assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr = req & wb_we_i;
	assign busy = (state == depec_pkg::ST_BUSY);

	always_ff @(posedge clk)
	begin
		if (rst)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= req;
	end

	always_comb
	begin
		next_rdata = 32'h00000000;
		case (wb_adr_i)
			depec_pkg::ADDR_CONTROL: next_rdata = {16'h0000, busy, ctrl[14:0]};
			depec_pkg::ADDR_KEY: next_rdata = 32'h00000000;
			depec_pkg::ADDR_TABLE_POINTER: next_rdata = {8'h00, table_pointer};
			depec_pkg::ADDR_TABLE_DATA:
			begin
				// reading during an operation returns the old contents
				if (in_range(table_pointer))
					next_rdata = {16'h0000, mem[table_pointer[8:1]]};
			end
			depec_pkg::ADDR_STATUS: next_rdata = {30'h00000000, busy, done_flag};
			depec_pkg::ADDR_CAPTURED: next_rdata = {8'h00, captured_addr};
			default: next_rdata = 32'h00000000;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			wb_dat_o <= 32'h00000000;
		else if (req & ~wb_we_i)
			wb_dat_o <= next_rdata;
	end

	////////////////////////////////////////////////////////////////////////////////
	// unlock key sequence: any other access in between relocks, except a repeated first key write, which keeps the first half
	always_ff @(posedge clk)
	begin
		if (rst)
			key_state <= depec_pkg::KEY_LOCKED;
		else if (req)
		begin
			case (key_state)
				depec_pkg::KEY_LOCKED:
				begin
					if (wr && wb_adr_i == depec_pkg::ADDR_KEY && wb_sel_i[0] && wb_dat_i[7:0] == depec_pkg::KEY_FIRST)
						key_state <= depec_pkg::KEY_HALF;
				end
				depec_pkg::KEY_HALF:
				begin
					if (wr && wb_adr_i == depec_pkg::ADDR_KEY && wb_sel_i[0] && wb_dat_i[7:0] == depec_pkg::KEY_SECOND)
						key_state <= depec_pkg::KEY_OPEN;
					else if (wr && wb_adr_i == depec_pkg::ADDR_KEY && wb_sel_i[0]
						&& wb_dat_i[7:0] == depec_pkg::KEY_FIRST)
						key_state <= depec_pkg::KEY_HALF;
					else
						key_state <= depec_pkg::KEY_LOCKED;
				end
				depec_pkg::KEY_OPEN:
				begin
					// the window closes after this one access, whatever it was
					if (wr && wb_adr_i == depec_pkg::ADDR_KEY && wb_sel_i[0] && wb_dat_i[7:0] == depec_pkg::KEY_FIRST)
						key_state <= depec_pkg::KEY_HALF;
					else
						key_state <= depec_pkg::KEY_LOCKED;
				end
				default: key_state <= depec_pkg::KEY_LOCKED;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// control register
	assign ctrl_accept = wr && (wb_adr_i == depec_pkg::ADDR_CONTROL) && (key_state == depec_pkg::KEY_OPEN)
		&& !busy;
	assign new_ctrl_raw = 16'(apply_sel({16'h0000, ctrl}, wb_dat_i, wb_sel_i));
	assign new_ctrl = new_ctrl_raw & depec_pkg::CONTROL_WRITE_MASK;
	assign new_kind = op_decode(new_ctrl[depec_pkg::BIT_ERASE_SEL], new_ctrl[5:0]);
	assign launch = ctrl_accept && new_ctrl_raw[depec_pkg::BIT_START]
		&& new_ctrl[depec_pkg::BIT_PERMIT]
		&& (new_kind != depec_pkg::OPK_NONE)
		&& (new_kind == depec_pkg::OPK_BULK || in_range(captured_addr));
	assign abort_ev = busy && abort_req;
	assign done_ev = busy && !abort_req && (count == 16'h0001);

	always_ff @(posedge clk)
	begin
		if (rst)
			ctrl <= depec_pkg::CONTROL_RESET;
		else if (abort_ev)
		begin
			ctrl[depec_pkg::BIT_PERMIT] <= 1'b0;
			ctrl[depec_pkg::BIT_ERROR] <= 1'b1;
		end
		else if (done_ev)
		begin
			ctrl[depec_pkg::BIT_PERMIT] <= 1'b0;
			ctrl[depec_pkg::BIT_ERROR] <= 1'b0;
		end
		else if (ctrl_accept)
			ctrl <= new_ctrl;
	end

	////////////////////////////////////////////////////////////////////////////////
	// operation sequencer; the start bit reads as the busy state
	always_ff @(posedge clk)
	begin
		if (rst)
			state <= depec_pkg::ST_IDLE;
		else
		begin
			case (state)
				depec_pkg::ST_IDLE:
				begin
					if (launch)
						state <= depec_pkg::ST_BUSY;
				end
				depec_pkg::ST_BUSY:
				begin
					if (abort_ev || done_ev)
						state <= depec_pkg::ST_IDLE;
				end
				default: state <= depec_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			count <= 16'h0000;
			op_kind <= depec_pkg::OPK_NONE;
			op_index <= 8'h00;
			op_align <= depec_pkg::ALIGN_ONE;
			op_data <= depec_pkg::LATCH_RESET;
			op_skip <= 1'b0;
		end
		else if (launch)
		begin
			count <= (new_kind == depec_pkg::OPK_WRITE1) ? depec_pkg::WRITE_CYCLES : depec_pkg::ERASE_CYCLES;
			op_kind <= new_kind;
			op_index <= captured_addr[8:1];
			op_data <= write_latch;
			op_skip <= new_ctrl[depec_pkg::BIT_SKIP_ERASE];
			case (new_kind)
				depec_pkg::OPK_ERASE4: op_align <= depec_pkg::ALIGN_FOUR;
				depec_pkg::OPK_ERASE8: op_align <= depec_pkg::ALIGN_EIGHT;
				depec_pkg::OPK_BULK: op_align <= depec_pkg::ALIGN_ALL;
				default: op_align <= depec_pkg::ALIGN_ONE;
			endcase
		end
		else if (busy)
			count <= count - 16'h0001;
	end

	////////////////////////////////////////////////////////////////////////////////
	// array: changes land at completion only, so an aborted cycle leaves it untouched
	always_ff @(posedge clk)
	begin
		if (done_ev)
		begin
			for (int i = 0; i < depec_pkg::EE_WORDS; i++)
			begin
				if (((8'(i) ^ op_index) & op_align) == 8'h00)
				begin
					if (op_kind != depec_pkg::OPK_WRITE1)
						mem[i] <= depec_pkg::ERASED_WORD;
					else if (op_skip)
						mem[i] <= mem[i] & op_data;
					else
						mem[i] <= op_data;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// table pointer, table write capture and done flag
	always_ff @(posedge clk)
	begin
		if (rst)
			table_pointer <= depec_pkg::POINTER_RESET;
		else if (wr && wb_adr_i == depec_pkg::ADDR_TABLE_POINTER)
			table_pointer <= 24'(apply_sel({8'h00, table_pointer}, wb_dat_i, {1'b0, wb_sel_i[2:0]}));
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			captured_addr <= depec_pkg::POINTER_RESET;
			write_latch <= depec_pkg::LATCH_RESET;
		end
		else if (wr && wb_adr_i == depec_pkg::ADDR_TABLE_DATA)
		begin
			captured_addr <= {1'b0, table_pointer[22:1], 1'b0};
			write_latch <= 16'(apply_sel({16'h0000, write_latch}, wb_dat_i, {2'b00, wb_sel_i[1:0]}));
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			done_flag <= 1'b0;
		else if (done_ev)
			done_flag <= 1'b1;
		else if (wr && wb_adr_i == depec_pkg::ADDR_STATUS && wb_sel_i[0] && wb_dat_i[depec_pkg::BIT_DONE])
			done_flag <= 1'b0;
	end

endmodule // depec_top

// >>> hdl/depec_top_fix.sv
// holds no logic: the whole controller sits in depec_top
// assumes nothing of its surroundings

// >>> shared/depec_pkg.sv
// constants, types and register map of the data eeprom program/erase controller
// assumes a single 25 MHz system clock and a classic wishbone register bus with 32-bit data

package depec_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// register byte offsets
	localparam logic [7:0] ADDR_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_KEY = 8'h04;
	localparam logic [7:0] ADDR_TABLE_POINTER = 8'h08;
	localparam logic [7:0] ADDR_TABLE_DATA = 8'h0C;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [7:0] ADDR_CAPTURED = 8'h14;

	////////////////////////////////////////////////////////////////////////////////
	// control register layout
	localparam int BIT_START = 15;
	localparam int BIT_PERMIT = 14;
	localparam int BIT_ERROR = 13;
	localparam int BIT_SKIP_ERASE = 12;
	localparam int BIT_ERASE_SEL = 6;
	localparam logic [15:0] CONTROL_WRITE_MASK = 16'h707F;
	localparam logic [15:0] CONTROL_RESET = 16'h0000;
	localparam int BIT_DONE = 0;
	localparam int BIT_BUSY = 1;

	////////////////////////////////////////////////////////////////////////////////
	// unlock key values
	localparam logic [7:0] KEY_FIRST = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'hAA;

	////////////////////////////////////////////////////////////////////////////////
	// array geometry
	localparam logic [23:0] EE_BASE = 24'h7FFE00;
	localparam int EE_WORDS = 256;
	localparam logic [15:0] ERASED_WORD = 16'hFFFF;
	localparam logic [23:0] POINTER_RESET = 24'h000000;
	localparam logic [15:0] LATCH_RESET = 16'hFFFF;

	////////////////////////////////////////////////////////////////////////////////
	// operation codes
	localparam logic [5:0] OP_ERASE8 = 6'h1A;
	localparam logic [5:0] OP_ERASE4 = 6'h19;
	localparam logic [5:0] OP_ERASE1 = 6'h18;
	localparam logic [3:0] OP_BULK_PREFIX = 4'h4;
	localparam logic [3:0] OP_WRITE_PREFIX = 4'h1;
	localparam logic [7:0] ALIGN_ONE = 8'hFF;
	localparam logic [7:0] ALIGN_FOUR = 8'hFC;
	localparam logic [7:0] ALIGN_EIGHT = 8'hF8;
	localparam logic [7:0] ALIGN_ALL = 8'h00;

	////////////////////////////////////////////////////////////////////////////////
	// timing: self-timed cycle lengths, rounded up to whole clocks
	localparam int CLK_PERIOD_NS = 40;
	localparam int ERASE_TIME_NS = 4000;
	localparam int WRITE_TIME_NS = 4000;
	localparam logic [15:0] ERASE_CYCLES = 16'((ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [15:0] WRITE_CYCLES = 16'((WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	////////////////////////////////////////////////////////////////////////////////
	// types
	typedef enum logic [2:0] {
		OPK_NONE = 3'h0,
		OPK_ERASE1 = 3'h1,
		OPK_ERASE4 = 3'h2,
		OPK_ERASE8 = 3'h3,
		OPK_BULK = 3'h4,
		OPK_WRITE1 = 3'h5
	} depec_op_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_BUSY = 2'b10
	} depec_state_t;

	typedef enum logic [2:0] {
		KEY_LOCKED = 3'b001,
		KEY_HALF = 3'b010,
		KEY_OPEN = 3'b100
	} depec_key_t;

endpackage
